//--- verilog/dmu_move_unit.sv
// Purpose: decode and execute the data move instructions
// Assumes: effective address forms are resolved here; storage answers with ack
// Notes:   one storage request at a time; registers live inside this block
`timescale 1ns/1ps
module dmu_move_unit (
  // clock and reset
  input  wire logic              CLOCK,
  input  wire logic              RESETN,
  // instruction from the sequencer
  input  wire logic              START,
  input  wire dmu_pkg::dmu_instr_s INSTR,
  input  wire logic              INTR_PEND,
  output logic                   BUSY,
  output logic                   DONE,
  output logic                   PCHK_INVADDR,
  output logic                   PCHK_SPEC,
  output logic                   INTERRUPTED,
  // indicators
  output dmu_pkg::dmu_ind_s      IND,
  // general registers access while idle
  input  wire logic              REG_WE,
  input  wire logic [2:0]        REG_WSEL,
  input  wire logic [15:0]       REG_WDATA,
  input  wire logic [2:0]        REG_RSEL,
  output logic [15:0]            REG_RDATA,
  // main storage
  output logic                   MEM_REQ,
  output logic                   MEM_WE,
  output logic                   MEM_BYTE,
  output logic [15:0]            MEM_ADDR,
  output logic [15:0]            MEM_WDATA,
  input  wire logic              MEM_ACK,
  input  wire logic              MEM_ERR,
  input  wire logic [15:0]       MEM_RDATA
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] ea_pre(input logic [1:0] am, input logic [15:0] base, input logic [15:0] app);
    ea_pre = (am == dmu_pkg::AM_APPEND || am == dmu_pkg::AM_INDIR) ? base + app : base;
  endfunction
  function automatic dmu_pkg::dmu_ind_s ind_of(input logic [15:0] hi, input logic [15:0] lo, input logic dbl);
    ind_of.neg  = hi[15];
    ind_of.even = dbl ? ~lo[0] : ~hi[0];
    ind_of.zero = dbl ? ({hi, lo} == 32'h0000_0000) : (hi == 16'h0000);
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  dmu_pkg::dmu_state_e state_ff;
  dmu_pkg::dmu_instr_s ins_ff;
  dmu_pkg::dmu_ind_s   ind_ff;
  logic [15:0] gpr_ff [8];
  logic [15:0] a1_ff, a2_ff, d0_ff, d1_ff, p1_ff, p2_ff, cnt_ff;
  logic [7:0]  byte_ff;
  logic        idx_ff, done_ff, inv_ff, spec_ff, intr_ff;

  // ----------------------------------------
  // decode; the latched word stays valid for the whole instruction
  // ----------------------------------------
  wire [15:0] w      = ins_ff.word;
  wire [4:0]  opc    = w[dmu_pkg::POS_OPC +: 5];
  wire [2:0]  r      = w[dmu_pkg::POS_R +: 3];
  wire [2:0]  r_nxt  = r + 3'h1;
  wire [2:0]  rb     = {1'b0, w[dmu_pkg::POS_RB +: 2]};
  wire [1:0]  am     = w[dmu_pkg::POS_AM +: 2];
  wire        dir    = w[dmu_pkg::POS_DIR];
  wire [2:0]  rb1    = {1'b0, w[dmu_pkg::POS_RB1 +: 2]};
  wire [2:0]  rb2    = {1'b0, w[dmu_pkg::POS_RB2 +: 2]};
  wire [1:0]  am1    = w[dmu_pkg::POS_AM1 +: 2];
  wire [1:0]  am2    = w[dmu_pkg::POS_AM2 +: 2];
  wire [2:0]  r2     = w[dmu_pkg::POS_R2 +: 3];
  wire        up     = w[dmu_pkg::POS_STEP];
  wire        lind   = w[dmu_pkg::POS_IND];
  wire is_dbl_rs = (opc == dmu_pkg::OPC_DBL_RS) && (w[2:0] == dmu_pkg::FN_DBL_RS);
  wire is_clr    = (opc == dmu_pkg::OPC_DBL_RS) && (w[3:0] == dmu_pkg::FN_DBL_CLR);
  wire is_dbl_ss = (opc == dmu_pkg::OPC_DBL_SS) && (w[1:0] == dmu_pkg::FN_SS);
  wire is_field  = (opc == dmu_pkg::OPC_FIELD) && (w[1:0] == dmu_pkg::FN_FIELD);
  wire is_wrr    = (opc == dmu_pkg::OPC_WRD_RR);
  wire is_wrs    = (opc == dmu_pkg::OPC_WRD_RS) && (w[2:0] == dmu_pkg::FN_WRD_RS);
  wire is_long   = (opc == dmu_pkg::OPC_WRD_LNG) && (w[2:0] == dmu_pkg::FN_LONG);
  wire is_wss    = (opc == dmu_pkg::OPC_WRD_SS) && (w[1:0] == dmu_pkg::FN_SS);
  wire is_imr    = (opc == dmu_pkg::OPC_IMM) && (w[2:0] == dmu_pkg::FN_IMM_REG);
  wire is_ims    = (opc == dmu_pkg::OPC_IMM) && (w[2:0] == dmu_pkg::FN_IMM_STO);
  wire is_ss     = is_dbl_ss | is_wss;
  wire is_rs     = is_dbl_rs | is_wrs | is_long;
  wire any_op    = is_rs | is_clr | is_ss | is_field | is_wrr | is_imr | is_ims;
  wire dbl       = is_dbl_rs | is_clr | is_dbl_ss;
  wire rd_mem    = (is_rs & ~dir) | is_clr | is_ss;
  wire wr_mem    = (is_rs & dir) | is_clr | is_ss | is_ims;
  wire to_reg    = (is_rs & ~dir) | is_clr | is_imr | is_wrr;
  wire [2:0] tgt = is_wrr ? r2 : r;

  // ----------------------------------------
  // address generation
  // ----------------------------------------
  wire [2:0]  base1 = is_ss ? rb1 : rb;
  wire [1:0]  am_1  = is_ss ? am1 : am;
  wire [15:0] long_a = (r2 == dmu_pkg::REG_ZERO) ? ins_ff.app1 : gpr_ff[r2] + ins_ff.app1;
  // immediate store keeps the immediate in the first appended word
  wire [15:0] app_a1 = is_ims ? ins_ff.app2 : ins_ff.app1;
  wire [15:0] ea1_pre = is_long ? long_a : ea_pre(am_1, gpr_ff[base1], app_a1);
  wire [15:0] ea2_pre = ea_pre(am2, gpr_ff[rb2], ins_ff.app2);
  wire        ind1 = is_long ? lind : (am_1 == dmu_pkg::AM_INDIR);
  wire        ind2 = is_ss & (am2 == dmu_pkg::AM_INDIR);
  // base step is committed at decode, so a later abort still leaves it done
  wire inc1 = (state_ff == dmu_pkg::S_DEC) & ~is_long & ~is_field & ~is_wrr & (am_1 == dmu_pkg::AM_POSTINC);
  wire inc2 = (state_ff == dmu_pkg::S_DEC) & is_ss & (am2 == dmu_pkg::AM_POSTINC);

  // ----------------------------------------
  // next-state selection
  // ----------------------------------------
  wire idx_last = (idx_ff == dbl);
  dmu_pkg::dmu_state_e data_nxt, ind1_nxt, dec_nxt;
  assign data_nxt = rd_mem ? dmu_pkg::S_RD : (wr_mem ? dmu_pkg::S_WR : dmu_pkg::S_FIN);
  assign ind1_nxt = ind2 ? dmu_pkg::S_IND2 : data_nxt;
  assign dec_nxt  = is_field ? ((gpr_ff[dmu_pkg::FIELD_COUNT_REG] == dmu_pkg::WORD_RESET) ? dmu_pkg::S_FIN
                                                                                         : dmu_pkg::S_FRD)
                  : (~any_op | is_wrr) ? dmu_pkg::S_FIN
                  : ind1 ? dmu_pkg::S_IND1 : ind1_nxt;

  // ----------------------------------------
  // storage port
  // ----------------------------------------
  wire        word_st  = (state_ff == dmu_pkg::S_IND1) | (state_ff == dmu_pkg::S_IND2)
                       | (state_ff == dmu_pkg::S_RD) | (state_ff == dmu_pkg::S_WR);
  wire        byte_st  = (state_ff == dmu_pkg::S_FRD) | (state_ff == dmu_pkg::S_FWR);
  wire [15:0] off      = idx_ff ? dmu_pkg::DBL_STEP : dmu_pkg::WORD_RESET;
  wire [15:0] wr_base  = is_ss ? a2_ff : a1_ff;
  logic [15:0] cur_addr;
  always_comb begin
    case (state_ff)
      dmu_pkg::S_IND1: cur_addr = a1_ff;
      dmu_pkg::S_IND2: cur_addr = a2_ff;
      dmu_pkg::S_RD:   cur_addr = a1_ff + off;
      dmu_pkg::S_WR:   cur_addr = wr_base + off;
      dmu_pkg::S_FRD:  cur_addr = p1_ff;
      dmu_pkg::S_FWR:  cur_addr = p2_ff;
      default:         cur_addr = dmu_pkg::WORD_RESET;
    endcase
  end
  wire spec_hit = word_st & cur_addr[0];
  wire mem_fail = (word_st | byte_st) & MEM_ACK & MEM_ERR;
  wire ack_ok   = MEM_ACK & ~MEM_ERR;
  wire [15:0] wr_word = is_clr ? dmu_pkg::WORD_RESET : (idx_ff ? d1_ff : d0_ff);
  assign MEM_REQ   = (word_st & ~cur_addr[0]) | byte_st;
  assign MEM_WE    = (state_ff == dmu_pkg::S_WR) | (state_ff == dmu_pkg::S_FWR);
  assign MEM_BYTE  = byte_st;
  assign MEM_ADDR  = cur_addr;
  assign MEM_WDATA = byte_st ? {8'h00, byte_ff} : wr_word;

  // ----------------------------------------
  // field stepping
  // ----------------------------------------
  wire [15:0] p1_step = up ? p1_ff + dmu_pkg::FIELD_STEP : p1_ff - dmu_pkg::FIELD_STEP;
  wire [15:0] p2_step = up ? p2_ff + dmu_pkg::FIELD_STEP : p2_ff - dmu_pkg::FIELD_STEP;
  wire [15:0] cnt_dec = cnt_ff - dmu_pkg::FIELD_STEP;
  wire        fld_end = (cnt_dec == dmu_pkg::WORD_RESET);
  wire [15:0] val0    = is_imr ? a1_ff : d0_ff;
  wire        fin_ok  = (state_ff == dmu_pkg::S_FIN) & ~inv_ff & ~spec_ff;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      state_ff <= dmu_pkg::S_IDLE;
      ins_ff   <= '0;
      ind_ff   <= '0;
      {a1_ff, a2_ff, d0_ff, d1_ff, p1_ff, p2_ff, cnt_ff} <= '0;
      byte_ff  <= 8'h00;
      {idx_ff, done_ff, inv_ff, spec_ff, intr_ff} <= '0;
    end else begin
      done_ff <= 1'b0;
      if (spec_hit) begin
        spec_ff  <= 1'b1;
        state_ff <= dmu_pkg::S_FIN;
      end else if (mem_fail) begin
        inv_ff   <= 1'b1;
        state_ff <= dmu_pkg::S_FIN;
      end else begin
        case (state_ff)
          dmu_pkg::S_IDLE: if (START) begin
            ins_ff   <= INSTR;
            {inv_ff, spec_ff, intr_ff} <= '0;
            state_ff <= dmu_pkg::S_DEC;
          end
          dmu_pkg::S_DEC: begin
            a1_ff    <= ea1_pre;
            a2_ff    <= ea2_pre;
            d0_ff    <= is_ims ? ins_ff.app1 : gpr_ff[r];
            d1_ff    <= gpr_ff[r_nxt];
            p1_ff    <= gpr_ff[r];
            p2_ff    <= gpr_ff[r2];
            cnt_ff   <= gpr_ff[dmu_pkg::FIELD_COUNT_REG];
            idx_ff   <= 1'b0;
            state_ff <= dec_nxt;
          end
          dmu_pkg::S_IND1: if (ack_ok) begin
            a1_ff    <= MEM_RDATA;
            state_ff <= ind1_nxt;
          end
          dmu_pkg::S_IND2: if (ack_ok) begin
            a2_ff    <= MEM_RDATA;
            state_ff <= data_nxt;
          end
          dmu_pkg::S_RD: if (ack_ok) begin
            if (idx_ff) d1_ff <= MEM_RDATA;
            else d0_ff <= MEM_RDATA;
            idx_ff   <= ~idx_last;
            if (idx_last) state_ff <= wr_mem ? dmu_pkg::S_WR : dmu_pkg::S_FIN;
          end
          dmu_pkg::S_WR: if (ack_ok) begin
            idx_ff   <= ~idx_last;
            if (idx_last) state_ff <= dmu_pkg::S_FIN;
          end
          dmu_pkg::S_FRD: if (ack_ok) begin
            byte_ff  <= MEM_RDATA[7:0];
            state_ff <= dmu_pkg::S_FWR;
          end
          dmu_pkg::S_FWR: if (ack_ok) begin
            p1_ff    <= p1_step;
            p2_ff    <= p2_step;
            cnt_ff   <= cnt_dec;
            ind_ff   <= ind_of({{8{byte_ff[7]}}, byte_ff}, dmu_pkg::WORD_RESET, 1'b0);
            // pending interrupt is honoured only between whole bytes
            intr_ff  <= ~fld_end & INTR_PEND;
            state_ff <= (fld_end | INTR_PEND) ? dmu_pkg::S_FIN : dmu_pkg::S_FRD;
          end
          dmu_pkg::S_FIN: begin
            if (fin_ok & any_op & ~is_field) ind_ff <= ind_of(val0, d1_ff, dbl);
            done_ff  <= 1'b1;
            state_ff <= dmu_pkg::S_IDLE;
          end
          default: state_ff <= dmu_pkg::S_IDLE;
        endcase
      end
    end
  end
  // ----------------------------------------
  // general registers; later writes win
  // ----------------------------------------
  wire fin_st = (state_ff == dmu_pkg::S_FIN);
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      for (int i = 0; i < 8; i++) gpr_ff[i] <= dmu_pkg::WORD_RESET;
    end else begin
      if (REG_WE && state_ff == dmu_pkg::S_IDLE) gpr_ff[REG_WSEL] <= REG_WDATA;
      if (inc1) gpr_ff[base1] <= gpr_ff[base1] + dmu_pkg::BASE_STEP;
      if (inc2) gpr_ff[rb2] <= gpr_ff[rb2] + dmu_pkg::BASE_STEP;
      // field progress is written back even on abort, so a restart resumes
      if (fin_st && is_field) begin
        gpr_ff[r]  <= p1_ff;
        gpr_ff[r2] <= p2_ff;
        gpr_ff[dmu_pkg::FIELD_COUNT_REG] <= cnt_ff;
      end
      if (fin_ok && to_reg) begin
        gpr_ff[tgt] <= val0;
        if (dbl) gpr_ff[r_nxt] <= d1_ff;
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign BUSY         = (state_ff != dmu_pkg::S_IDLE);
  assign DONE         = done_ff;
  assign PCHK_INVADDR = inv_ff;
  assign PCHK_SPEC    = spec_ff;
  assign INTERRUPTED  = intr_ff;
  assign IND          = ind_ff;
  assign REG_RDATA    = gpr_ff[REG_RSEL];
endmodule

//--- verilog/dmu_pkg.sv
// Purpose: constants and types for the data move instruction unit
// Assumes: 16-bit words, byte addresses, instruction bit 0 is the msb (vector bit 15)
// Notes:   vector positions below are lsb positions inside the 16-bit word
// Notes on behaviour
// - doubleword reg/storage: opcode 11010, function 000; source unchanged
// - register pair starting at 7 uses register 0 as second
// - bit 12 picks direction: 0 storage to register, 1 register to storage
// - carry, overflow untouched; even, negative, zero from the moved operand
// - doubleword storage/storage: opcode 10010, function 00; copy first to second
// - invalid address ends storage/storage; first base still steps on mode 01
// - odd indirect or word/doubleword operand address raises specification check
// - doubleword move and clear: opcode 11010, function 0101; load then zero storage
// - field move: opcode 00101; bit 13 zero decrements, one increments both addresses
// - field move count from register 7; zero count does nothing
// - per byte: copy, step both addresses, count down; stop at zero
// - field move may break between bytes; restart uses remaining count
// - field move sets even, negative, zero from last byte only
// - word reg/reg copies first register into second, no program check
// - long forms add appended field to index register; index zero adds nothing
// - long forms bit 11: zero direct, one fetches address from storage
// - word storage/storage copies first operand word to second
// - immediate to register loads the generated address value, sets indicators
// - immediate to storage writes immediate; modes 10, 11 take appended address word
// - address mode 01 steps the base register by two
package dmu_pkg;
  typedef logic [15:0] dmu_word_t;
  typedef struct packed {
    dmu_word_t word;
    dmu_word_t app1;
    dmu_word_t app2;
  } dmu_instr_s;
  typedef struct packed {
    logic even;
    logic neg;
    logic zero;
  } dmu_ind_s;
  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_DEC = 4'h1, S_IND1 = 4'h2, S_IND2 = 4'h3, S_RD = 4'h4,
    S_WR   = 4'h5, S_FRD = 4'h6, S_FWR  = 4'h7, S_FIN  = 4'h8
  } dmu_state_e;
  // opcodes, instruction bits 0-4
  localparam logic [4:0] OPC_DBL_RS  = 5'h1a;
  localparam logic [4:0] OPC_DBL_SS  = 5'h12;
  localparam logic [4:0] OPC_FIELD   = 5'h05;
  localparam logic [4:0] OPC_WRD_RR  = 5'h0b;
  localparam logic [4:0] OPC_WRD_RS  = 5'h19;
  localparam logic [4:0] OPC_WRD_LNG = 5'h0d;
  localparam logic [4:0] OPC_WRD_SS  = 5'h11;
  localparam logic [4:0] OPC_IMM     = 5'h0e;
  localparam logic [2:0] FN_DBL_RS   = 3'h0;
  localparam logic [3:0] FN_DBL_CLR  = 4'h5;
  localparam logic [1:0] FN_SS       = 2'h0;
  localparam logic [1:0] FN_FIELD    = 2'h0;
  localparam logic [2:0] FN_WRD_RS   = 3'h0;
  localparam logic [2:0] FN_LONG     = 3'h0;
  localparam logic [2:0] FN_IMM_REG  = 3'h0;
  localparam logic [2:0] FN_IMM_STO  = 3'h1;
  // field lsb positions
  localparam int POS_OPC  = 11;
  localparam int POS_R    = 8;
  localparam int POS_RB   = 6;
  localparam int POS_AM   = 4;
  localparam int POS_DIR  = 3;
  localparam int POS_RB1  = 9;
  localparam int POS_RB2  = 7;
  localparam int POS_AM1  = 5;
  localparam int POS_AM2  = 3;
  localparam int POS_R2   = 5;
  localparam int POS_STEP = 2;
  localparam int POS_IND  = 4;
  // address modes
  localparam logic [1:0] AM_DIRECT  = 2'h0;
  localparam logic [1:0] AM_POSTINC = 2'h1;
  localparam logic [1:0] AM_APPEND  = 2'h2;
  localparam logic [1:0] AM_INDIR   = 2'h3;
  localparam logic [2:0]  FIELD_COUNT_REG = 3'h7;
  localparam logic [2:0]  REG_ZERO        = 3'h0;
  localparam logic [15:0] BASE_STEP       = 16'h0002;
  localparam logic [15:0] DBL_STEP        = 16'h0002;
  localparam logic [15:0] FIELD_STEP      = 16'h0001;
  localparam logic [15:0] WORD_RESET      = 16'h0000;
endpackage

//--- test/dmu_store_model.sv
// Purpose: main storage seen from the move unit, 4 KiB of bytes
// Assumes: addresses from 16'h1000 upward are invalid and answered with an error
// Notes:   wait cycles set by the bench; released read data toggles so it never looks valid
`timescale 1ns/1ps
module dmu_store_model (
  // clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RESETN,
  // storage side
  input  wire logic        MEM_REQ,
  input  wire logic        MEM_WE,
  input  wire logic        MEM_BYTE,
  input  wire logic [15:0] MEM_ADDR,
  input  wire logic [15:0] MEM_WDATA,
  output logic             MEM_ACK,
  output logic             MEM_ERR,
  output logic [15:0]      MEM_RDATA,
  // pacing
  input  wire logic [1:0]  WAIT_CYC
);
  // ------------------------------------------------------------
  // storage array and answer
  // ------------------------------------------------------------
  logic [7:0]  mem [0:4095];
  logic [1:0]  wait_ff;
  logic [11:0] a;
  logic        bad;
  assign a = MEM_ADDR[11:0];
  assign bad = |MEM_ADDR[15:12];
  // behavioural on purpose: the bench preloads mem directly
  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      MEM_ACK <= 1'b0;
      MEM_ERR <= 1'b0;
      MEM_RDATA <= 16'h5a5a;
      wait_ff <= 2'h0;
    end else if (MEM_REQ && !MEM_ACK && wait_ff >= WAIT_CYC) begin
      MEM_ACK <= 1'b1;
      MEM_ERR <= bad;
      wait_ff <= 2'h0;
      MEM_RDATA <= bad ? ~MEM_RDATA : MEM_BYTE ? {8'h00, mem[a]} : {mem[a], mem[a + 12'h1]};
      if (!bad && MEM_WE && MEM_BYTE) begin
        mem[a] <= MEM_WDATA[7:0];
      end else if (!bad && MEM_WE) begin
        mem[a] <= MEM_WDATA[15:8];
        mem[a + 12'h1] <= MEM_WDATA[7:0];
      end
    end else begin
      MEM_ACK <= 1'b0;
      MEM_ERR <= 1'b0;
      MEM_RDATA <= ~MEM_RDATA;
      wait_ff <= (MEM_REQ && !MEM_ACK) ? wait_ff + 2'h1 : 2'h0;
    end
  end
endmodule

//--- test/dmu_move_unit_asserts.sv
// Purpose: port-level checks of the data move instruction unit
// Assumes: opcode in word[15:11], function in word[3:0]
// Notes:   bound to every instance of the move unit
`timescale 1ns/1ps
module dmu_move_unit_asserts (
  // clock and reset
  input  wire logic                CLOCK,
  input  wire logic                RESETN,
  // instruction side
  input  wire logic                START,
  input  wire dmu_pkg::dmu_instr_s INSTR,
  input  wire logic                BUSY,
  input  wire logic                DONE,
  input  wire logic                PCHK_INVADDR,
  input  wire logic                PCHK_SPEC,
  input  wire logic                INTERRUPTED,
  input  wire dmu_pkg::dmu_ind_s   IND,
  // storage side
  input  wire logic                MEM_REQ,
  input  wire logic                MEM_WE,
  input  wire logic                MEM_BYTE,
  input  wire logic [15:0]         MEM_ADDR,
  input  wire logic [15:0]         MEM_WDATA,
  input  wire logic                MEM_ACK,
  input  wire logic                MEM_ERR
);
  // ------------------------------------------------------------
  // latched opcode and assertions
  // ------------------------------------------------------------
  logic [4:0] op_ff;
  logic [3:0] fn_ff;
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      op_ff <= 5'h00;
      fn_ff <= 4'h0;
    end else if (START && !BUSY) begin
      op_ff <= INSTR.word[15:11];
      fn_ff <= INSTR.word[3:0];
    end
  end
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESETN);
  a_done_single: assert property (DONE |=> !DONE) else $error("done wider than one cycle");
  a_req_held: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR) && $stable(MEM_WE)
    && $stable(MEM_WDATA)) else $error("storage request changed before ack");
  a_word_even: assert property (MEM_REQ && !MEM_BYTE |-> !MEM_ADDR[0]) else $error("odd word access");
  a_rr_quick: assert property (START && !BUSY && INSTR.word[15:11] == dmu_pkg::OPC_WRD_RR
    |=> !MEM_REQ [*2] ##1 (DONE && !PCHK_SPEC && !PCHK_INVADDR)) else $error("reg to reg move wrong");
  a_field_bytes: assert property (BUSY && op_ff == dmu_pkg::OPC_FIELD && MEM_REQ |-> MEM_BYTE)
    else $error("field move used a word access");
  a_clear_zero: assert property (BUSY && op_ff == dmu_pkg::OPC_DBL_RS && fn_ff == dmu_pkg::FN_DBL_CLR
    && MEM_REQ && MEM_WE |-> MEM_WDATA == 16'h0000) else $error("clear wrote nonzero");
  a_load_no_write: assert property (BUSY && op_ff == dmu_pkg::OPC_DBL_RS && fn_ff == 4'h0
    && MEM_REQ |-> !MEM_WE) else $error("load wrote storage");
  a_flags_cleared: assert property (START && !BUSY |=> !PCHK_SPEC && !PCHK_INVADDR && !INTERRUPTED)
    else $error("flags not cleared on start");
  a_ind_quiet: assert property (!BUSY && !START |=> $stable(IND)) else $error("indicators moved while idle");
  a_err_ends: assert property (MEM_REQ && MEM_ACK && MEM_ERR |=> !MEM_REQ ##[0:3] (DONE && PCHK_INVADDR))
    else $error("invalid address did not end instruction");
  a_intr_quick: assert property ($rose(INTERRUPTED) |-> ##[0:2] DONE) else $error("interrupt did not end");
  a_req_busy: assert property (MEM_REQ |-> BUSY) else $error("storage request while idle");
endmodule
bind dmu_move_unit dmu_move_unit_asserts u_chk (.CLOCK(CLOCK), .RESETN(RESETN), .START(START), .INSTR(INSTR),
  .BUSY(BUSY), .DONE(DONE), .PCHK_INVADDR(PCHK_INVADDR), .PCHK_SPEC(PCHK_SPEC), .INTERRUPTED(INTERRUPTED),
  .IND(IND), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_BYTE(MEM_BYTE), .MEM_ADDR(MEM_ADDR),
  .MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK), .MEM_ERR(MEM_ERR));

//--- test/tb_data_move_instruction_unit.sv
// Purpose: self-checking bench for the data move instruction unit
// Assumes: storage model waits 0 to 3 cycles; addresses from 16'h1000 are invalid
// Notes:   expectations come from bench functions; only the zero-count field indicator check reuses the IND seen before the run
`timescale 1ns/1ps
module tb_data_move_instruction_unit;
  // ------------------------------------------------------------
  // signals, tasks
  // ------------------------------------------------------------
  logic CLOCK = 1'b0, RESETN = 1'b0, START = 1'b0, INTR_PEND = 1'b0, REG_WE = 1'b0;
  dmu_pkg::dmu_instr_s INSTR = '0;
  logic [2:0] REG_WSEL = 3'h0, REG_RSEL = 3'h0;
  logic [15:0] REG_WDATA = 16'h0000, REG_RDATA, MEM_ADDR, MEM_WDATA, MEM_RDATA;
  logic [1:0] wait_cyc = 2'h0;
  logic BUSY, DONE, PCHK_INVADDR, PCHK_SPEC, INTERRUPTED, MEM_REQ, MEM_WE, MEM_BYTE, MEM_ACK, MEM_ERR;
  dmu_pkg::dmu_ind_s IND;
  int comparisons = 0, fail_count = 0, cycles = 0;
  dmu_move_unit DUT (.CLOCK(CLOCK), .RESETN(RESETN), .START(START), .INSTR(INSTR), .INTR_PEND(INTR_PEND),
    .BUSY(BUSY), .DONE(DONE), .PCHK_INVADDR(PCHK_INVADDR), .PCHK_SPEC(PCHK_SPEC), .INTERRUPTED(INTERRUPTED),
    .IND(IND), .REG_WE(REG_WE), .REG_WSEL(REG_WSEL), .REG_WDATA(REG_WDATA), .REG_RSEL(REG_RSEL),
    .REG_RDATA(REG_RDATA), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_BYTE(MEM_BYTE), .MEM_ADDR(MEM_ADDR),
    .MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK), .MEM_ERR(MEM_ERR), .MEM_RDATA(MEM_RDATA));
  dmu_store_model u_mem (.CLOCK(CLOCK), .RESETN(RESETN), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_BYTE(MEM_BYTE),
    .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK), .MEM_ERR(MEM_ERR), .MEM_RDATA(MEM_RDATA),
    .WAIT_CYC(wait_cyc));
  always #2.5 CLOCK = ~CLOCK;
  task automatic print_verdict();
    $display("TB: %0d comparisons, %0d mismatches", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ceiling far above the few hundred cycles the tests need
  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      print_verdict();
    end
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [2:0] ind(input logic [31:0] v, input int top);
    return {~v[0], v[top], v == 32'h0};
  endfunction
  function automatic void mw(input logic [15:0] a, input logic [15:0] v);
    u_mem.mem[a[11:0]] = v[15:8];
    u_mem.mem[a[11:0] + 12'h1] = v[7:0];
  endfunction
  function automatic logic [15:0] mr(input logic [15:0] a);
    return {u_mem.mem[a[11:0]], u_mem.mem[a[11:0] + 12'h1]};
  endfunction
  function automatic logic [11:0] fa(input logic [15:0] b, input int j, input int up);
    return 12'(up ? b + j : b - j);
  endfunction
  task automatic wr(input logic [2:0] s, input logic [15:0] v);
    @(negedge CLOCK);
    REG_WE = 1'b1;
    REG_WSEL = s;
    REG_WDATA = v;
    @(negedge CLOCK);
    REG_WE = 1'b0;
  endtask
  task automatic rd(input logic [2:0] s, output logic [15:0] v);
    REG_RSEL = s;
    #1 v = REG_RDATA;
  endtask
  task automatic run(input logic [15:0] w);
    int n;
    wait_cyc = 2'($urandom);
    @(negedge CLOCK);
    START = 1'b1;
    INSTR = {w, 16'($urandom), 16'($urandom)};
    @(negedge CLOCK);
    START = 1'b0;
    n = 0;
    while (DONE !== 1'b1 && n < 300) begin
      @(negedge CLOCK);
      n++;
    end
    check("done", DONE, 1'b1);
  endtask
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    logic [15:0] hi, lo, ea, a1, a2, got, w;
    logic [2:0]  prev;
    int          r, rb, am, st, n;
    got = 16'($urandom(32'h4f95));
    repeat (2) @(negedge CLOCK);
    RESETN = 1'b1;
    for (int i = 0; i < 4; i++) begin
      r = $urandom % 8;
      rb = (r + 1 + $urandom % 7) % 8;
      hi = (i == 0) ? 16'h0 : 16'($urandom);
      wr(r[2:0], hi);
      wr(rb[2:0], ~hi);
      run({dmu_pkg::OPC_WRD_RR, r[2:0], rb[2:0], 5'h00});
      rd(rb[2:0], got); check("rr dest", got, hi);
      rd(r[2:0], got); check("rr src", got, hi);
      check("rr ind", IND, ind(hi, 15));
    end
    $display("TB: register move test done");
    for (int i = 0; i < 6; i++) begin
      r = (i < 3) ? 7 : 4 + $urandom % 3;
      rb = 1 + $urandom % 3;
      am = $urandom % 2;
      st = i % 3;
      ea = 16'h0100 + {5'h00, 10'($urandom), 1'b0};
      hi = (i == 3) ? 16'h0 : 16'($urandom);
      lo = (i == 3) ? 16'h0 : 16'($urandom);
      mw(ea, st == 1 ? ~hi : hi);
      mw(ea + 16'h2, st == 1 ? ~lo : lo);
      wr(r[2:0], st == 1 ? hi : ~hi);
      wr(3'(r + 1), st == 1 ? lo : ~lo);
      wr(rb[2:0], ea);
      w = {dmu_pkg::OPC_DBL_RS, r[2:0], rb[1:0], am[1:0], st == 1, dmu_pkg::FN_DBL_RS};
      if (st == 2) w[3:0] = dmu_pkg::FN_DBL_CLR;
      run(w);
      rd(r[2:0], got); check("pair high", got, hi);
      rd(3'(r + 1), got); check("pair low", got, lo);
      check("mem high", mr(ea), st == 2 ? 16'h0 : hi);
      check("mem low", mr(ea + 16'h2), st == 2 ? 16'h0 : lo);
      rd(rb[2:0], got); check("base step", got, ea + (am ? 16'h2 : 16'h0));
      check("dbl ind", IND, ind({hi, lo}, 31));
    end
    wr(3'h1, 16'h0101);
    run({dmu_pkg::OPC_DBL_RS, 3'h4, 2'h1, 2'h0, 1'b0, 3'h0});
    check("odd addr", {PCHK_SPEC, PCHK_INVADDR}, 2'b10);
    for (int i = 0; i < 2; i++) begin
      hi = 16'($urandom);
      lo = 16'($urandom);
      mw(16'h0200, hi);
      mw(16'h0202, lo);
      mw(16'h0300, 16'h0);
      mw(16'h0302, 16'h0);
      wr(3'h1, 16'h0200);
      wr(3'h2, i ? 16'h9000 : 16'h0300);
      run({dmu_pkg::OPC_DBL_SS, 2'h1, 2'h2, dmu_pkg::AM_POSTINC, dmu_pkg::AM_DIRECT, 3'h0});
      check("ss invalid", PCHK_INVADDR, i);
      rd(3'h1, got); check("ss base", got, 16'h0202);
      check("ss src", mr(16'h0200), hi);
      check("ss dst", {mr(16'h0300), mr(16'h0302)}, i ? 32'h0 : {hi, lo});
    end
    $display("TB: doubleword tests done");
    for (int k = 0; k < 4; k++) begin
      st = k % 2;
      n = (k == 2) ? 5 : (k == 3) ? 0 : 1 + $urandom % 6;
      a1 = 16'h0480;
      a2 = 16'h0680;
      for (int j = 0; j < 8; j++) begin
        u_mem.mem[fa(a1, j, st)] = 8'($urandom);
        u_mem.mem[fa(a2, j, st)] = 8'hee;
      end
      wr(3'h7, 16'(n));
      wr(3'h1, a1);
      wr(3'h2, a2);
      prev = IND;
      w = {dmu_pkg::OPC_FIELD, 3'h1, 3'h2, 2'b00, st[0], 2'b00};
      if (k == 2) begin
        INTR_PEND = 1'b1;
        run(w);
        check("intr flag", INTERRUPTED, 1'b1);
        rd(3'h7, got); check("intr count", got, 16'h4);
        INTR_PEND = 1'b0;
      end
      run(w);
      for (int j = 0; j < n; j++) check("field byte", u_mem.mem[fa(a2, j, st)], u_mem.mem[fa(a1, j, st)]);
      rd(3'h1, got); check("field r1", got, 16'(fa(a1, n, st)) | (a1 & 16'hf000));
      rd(3'h2, got); check("field r2", got, 16'(fa(a2, n, st)) | (a2 & 16'hf000));
      rd(3'h7, got); check("field count", got, 16'h0);
      check("field ind", IND, n ? ind(u_mem.mem[fa(a1, n - 1, st)], 7) : prev);
    end
    wr(3'h7, 16'h0003);
    wr(3'h2, 16'h9000);
    run({dmu_pkg::OPC_FIELD, 3'h1, 3'h2, 5'h04});
    check("field invalid", PCHK_INVADDR, 1'b1);
    $display("TB: field move tests done");
    print_verdict();
  end
endmodule
